// file: rtl/cupm_defs.svh
/*
 Register offsets, field positions, key values and reset values of the
 clock unlock / loop / monitor block. Assumes 32-bit APB data.
*/
`ifndef CUPM_DEFS_SVH
`define CUPM_DEFS_SVH
`define CUPM_OFF_KEY 8'h00
`define CUPM_OFF_SCCR 8'h04
`define CUPM_OFF_CMRR 8'h08
`define CUPM_OFF_PLL 8'h0c
`define CUPM_OFF_NMI 8'h10
`define CUPM_OFF_LVI 8'h14
`define CUPM_OFF_IST 8'h18
`define CUPM_OFF_IMSK 8'h1c
`define CUPM_KEY_FIRST 8'h57
`define CUPM_KEY_SECOND 8'h75
`define CUPM_B_UNLOCK 8
`define CUPM_F_KEY 7:0
`define CUPM_B_XSRC 12
`define CUPM_F_MCS 2:0
`define CUPM_B_MON_ON 3
`define CUPM_B_FAIL_RST 2
`define CUPM_B_FAIL 1
`define CUPM_B_LOCK 31
`define CUPM_B_RSTREL 23
`define CUPM_B_PWRON 22
`define CUPM_B_BYPOFF 21
`define CUPM_B_DOUBLE 20
`define CUPM_F_PRE 18:16
`define CUPM_F_MULT 15:8
`define CUPM_F_POST 7:4
`define CUPM_F_OUT 3:0
`define CUPM_WM_SCCR 32'h0000_1007
`define CUPM_WM_PLL 32'h00ff_ffff
`define CUPM_RST_REG 32'h0000_0000
`define CUPM_IRQ_FAIL 0
`define CUPM_IRQ_LOCK 1
`define CUPM_IRQ_NMI 2
`define CUPM_IRQ_LVI 3
`define CUPM_MON_TICKS 8
`endif

// file: rtl/cupm_pkg.sv
/*
 Types shared by the clock unlock / loop / monitor block.
 Assumes nothing of its surroundings.
*/
package cupm_pkg;
    typedef enum logic [1:0] {key_locked, key_half, key_open} cupm_key_t;
endpackage

// file: rtl/cupm_key_lock.sv
/*
 Two-write key sequencer that opens the protected registers.
 Assumes key_wr is a one-cycle pulse on a completed APB key write.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cupm_defs.svh"
module cupm_key_lock import cupm_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic key_wr,
    input wire logic [7:0] key_data,
    output logic unlocked
);
    cupm_key_t state;
    cupm_key_t next_state;

    always_comb begin
        next_state = state;
        if (key_wr) begin
            case (state)
                key_locked: begin
                    if (key_data == `CUPM_KEY_FIRST)
                        next_state = key_half;
                end
                key_half: begin
                    if (key_data == `CUPM_KEY_SECOND)
                        next_state = key_open; // [R01]
                    else
                        next_state = key_locked; // [R18]
                end
                key_open: begin
                    // Any other value relocks; a fresh first key restarts
                    if (key_data == `CUPM_KEY_FIRST)
                        next_state = key_half;
                    else
                        next_state = key_locked; // [R02]
                end
                default: next_state = key_locked;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            state <= key_locked;
        else
            state <= next_state;
    end

    assign unlocked = (state == key_open);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus spacing between key writes varies, so each step stands alone
    sequence s_first;
        (state == key_locked) && key_wr && key_data == `CUPM_KEY_FIRST;
    endsequence
    sequence s_second;
        (state == key_half) && key_wr && key_data == `CUPM_KEY_SECOND;
    endsequence
    chk_key_arms: assert property (s_first |=> state == key_half)
        else $error("first key not accepted"); // [R01]
    chk_key_opens: assert property (s_second |=> unlocked)
        else $error("key pair did not unlock"); // [R01]
    chk_key_abort: assert property ((state == key_half) && key_wr &&
        key_data != `CUPM_KEY_SECOND |=> !unlocked ##1 !unlocked or key_wr)
        else $error("broken key sequence unlocked"); // [R18]
    chk_key_close: assert property (unlocked && key_wr |=> !unlocked)
        else $error("key write did not relock"); // [R02]
endmodule
`default_nettype wire

// file: rtl/cupm_xtal_mon.sv
/*
 Crystal stop monitor, timed by ticks of the low-speed internal osc.
 Assumes both inputs are synchronised one-cycle pulses on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cupm_defs.svh"
module cupm_xtal_mon #(
    parameter int TICKS = `CUPM_MON_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mon_on,
    input wire logic lsi_tick,
    input wire logic xtal_edge,
    output logic fail_evt
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_fail_evt;

    always_comb begin
        next_cnt = cnt;
        next_fail_evt = 1'b0;
        if (!mon_on || xtal_edge) begin
            next_cnt = 8'h0;
        end else if (lsi_tick && cnt < 8'(TICKS)) begin
            next_cnt = cnt + 8'h1;
            // Saturating count gives one event per stop
            next_fail_evt = (cnt == 8'(TICKS - 1)); // [R10]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h0;
            fail_evt <= 1'b0;
        end else begin
            cnt <= next_cnt;
            fail_evt <= next_fail_evt;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_mon_fires: assert property (mon_on && !xtal_edge && lsi_tick &&
        cnt == 8'(TICKS - 1) |=> fail_evt)
        else $error("stopped crystal not flagged"); // [R10]
    chk_mon_quiet: assert property (!mon_on |=> !fail_evt)
        else $error("failure raised while monitor off"); // [R10]
endmodule
`default_nettype wire

// file: rtl/cupm_top.sv
/*
 Clock unlock, frequency loop control, crystal monitor and main clock
 select, with an APB register slave and a level interrupt.
 Assumes a single pclk; oscillator heartbeats and events arrive as pins
 and are synchronised here. The loop itself is an analog macro outside.
*/
// The address map and the APB interface to the registers were decided locally.
// Function
// R01 - Writing 0x57 then 0x75 to the key field opens protected registers
// R02 - Any other key value afterwards relocks; stored contents stay put
// R03 - NMI and low-voltage status bits clear regardless of the key state
// R04 - Key register bit 8 reads 1 while unlocked, 0 while locked
// R05 - Software keeps the loop reference between 1 and 3 MHz
// R06 - Software keeps the oscillator between 50 and 200 MHz, no doubler
// R07 - Doubler multiplies by two; doubled output 100 to 250 MHz
// R08 - Output equals ref times (N1+1) over (N2+1)(P+1), times (D+1); the code also divides by loop_out_div plus one
// R09 - Output frequency is settable in whole-megahertz steps
// R10 - Enabled monitor raises reset or interrupt when the crystal stops
// R11 - Software does not run the core from a monitored crystal
// R12 - Software keeps the low-speed internal oscillator always running
// R13 - Monitor register: enable at bit 3, write-one-clear fail at bit 1
// R14 - Loop control bits 23, 22, 21: reset release, power on, bypass off
// R15 - Software waits for lock at bit 31 before selecting the loop
// R16 - Clock control bit 12 routes the crystal to the loop reference
// R17 - The key state gates writes to every protected register
// R18 - A wrong second key write aborts the sequence, staying locked
// R19 - Locked writes to protected registers are silently ignored
`timescale 1ns/1ps
`default_nettype none
`include "cupm_defs.svh"
module cupm_top import cupm_pkg::*; #(
    parameter logic [5:0] XTAL_MHZ = 6'h08,
    parameter logic [5:0] INT_MHZ = 6'h20,
    parameter int MON_TICKS = `CUPM_MON_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic lsi_clk_in,
    input wire logic xtal_beat_in,
    input wire logic loop_locked_in,
    input wire logic [3:0] nmi_event,
    input wire logic [3:0] lvi_event,
    output logic [2:0] main_clock_select,
    output logic loop_source_select,
    output logic loop_reset_release,
    output logic loop_power_on,
    output logic loop_bypass_off,
    output logic doubler_select,
    output logic [2:0] loop_pre_div,
    output logic [7:0] loop_mult,
    output logic [3:0] loop_post_div,
    output logic [3:0] loop_out_div,
    output logic [15:0] loop_fout_mhz,
    output logic xtal_fail_reset
);
    // Pin vector: {lvi, nmi, lock, crystal beat, lsi}
    logic [10:0] pin_meta;
    logic [10:0] pin_sync;
    logic [10:0] pin_last;
    logic [10:0] pin_rise;
    logic [31:0] sccr, next_sccr;
    logic [31:0] pll, next_pll;
    logic mon_on, next_mon_on;
    logic fail_rst, next_fail_rst;
    logic fail, next_fail;
    logic [3:0] nmi_st, next_nmi_st;
    logic [3:0] lvi_st, next_lvi_st;
    logic [3:0] ist, next_ist;
    logic [3:0] imsk, next_imsk;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_irq, next_fail_reset;
    logic [15:0] next_fout;
    logic lock_q;
    logic lock_st;
    logic unlocked;
    logic fail_evt;
    logic setup, acc, wr, rd, wr_ok, hit;
    logic [3:0] ev, rd_clr;
    logic [31:0] rmux;

    function automatic logic hit_of(input logic [7:0] a);
        case (a)
            `CUPM_OFF_KEY, `CUPM_OFF_SCCR, `CUPM_OFF_CMRR,
            `CUPM_OFF_PLL, `CUPM_OFF_NMI, `CUPM_OFF_LVI,
            `CUPM_OFF_IST, `CUPM_OFF_IMSK: hit_of = 1'b1;
            default: hit_of = 1'b0;
        endcase
    endfunction

    // Integer MHz result: steps of one megahertz by construction
    function automatic logic [15:0] fout_of(input logic [5:0] rf,
                                             input logic [31:0] c);
        logic [16:0] num;
        logic [16:0] den;
        logic [16:0] q;
        num = 17'(rf) * (17'(c[`CUPM_F_MULT]) + 17'h1) *
              (17'(c[`CUPM_B_DOUBLE]) + 17'h1); // [R07]
        den = (17'(c[`CUPM_F_PRE]) + 17'h1) *
              (17'(c[`CUPM_F_POST]) + 17'h1) *
              (17'(c[`CUPM_F_OUT]) + 17'h1);
        q = num / den; // [R08] [R09]
        fout_of = c[`CUPM_B_BYPOFF] ? q[15:0] : 16'(rf);
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 11'h0;
            pin_sync <= 11'h0;
            pin_last <= 11'h0;
        end else begin
            pin_meta <= {lvi_event, nmi_event, loop_locked_in,
                         xtal_beat_in, lsi_clk_in};
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end
    assign pin_rise = pin_sync & ~pin_last;

    cupm_key_lock u_key (
        .pclk(pclk),
        .presetn(presetn),
        .key_wr(wr && paddr == `CUPM_OFF_KEY),
        .key_data(pwdata[`CUPM_F_KEY]),
        .unlocked(unlocked)
    );

    cupm_xtal_mon #(.TICKS(MON_TICKS)) u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .mon_on(mon_on),
        .lsi_tick(pin_rise[0]),
        .xtal_edge(pin_sync[1] ^ pin_last[1]),
        .fail_evt(fail_evt)
    );

    // One wait state: data and error are ready with pready
    assign setup = psel && penable && !pready;
    assign acc = psel && penable && pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign wr_ok = wr && unlocked; // [R17] [R19]
    assign hit = hit_of(paddr);
    assign lock_st = pin_sync[2] && pll[`CUPM_B_RSTREL] &&
                     pll[`CUPM_B_PWRON];
    assign ev = {|pin_rise[10:7], |pin_rise[6:3], lock_st && !lock_q,
                 fail_evt && !fail_rst};
    // Only bits shown to software are cleared, so late events survive
    assign rd_clr = (rd && paddr == `CUPM_OFF_IST) ? prdata[3:0] : 4'h0;

    always_comb begin
        rmux = 32'h0;
        case (paddr)
            `CUPM_OFF_KEY: rmux[`CUPM_B_UNLOCK] = unlocked; // [R04]
            `CUPM_OFF_SCCR: rmux = sccr;
            `CUPM_OFF_CMRR: begin
                rmux[`CUPM_B_MON_ON] = mon_on;
                rmux[`CUPM_B_FAIL_RST] = fail_rst;
                rmux[`CUPM_B_FAIL] = fail;
            end
            `CUPM_OFF_PLL: begin
                rmux = pll;
                rmux[`CUPM_B_LOCK] = lock_st;
            end
            `CUPM_OFF_NMI: rmux[3:0] = nmi_st;
            `CUPM_OFF_LVI: rmux[3:0] = lvi_st;
            `CUPM_OFF_IST: rmux[3:0] = ist;
            `CUPM_OFF_IMSK: rmux[3:0] = imsk;
            default: rmux = 32'h0;
        endcase
    end

    always_comb begin
        next_sccr = sccr;
        next_pll = pll;
        next_mon_on = mon_on;
        next_fail_rst = fail_rst;
        next_imsk = imsk;
        if (wr_ok) begin
            case (paddr)
                `CUPM_OFF_SCCR: next_sccr = pwdata & `CUPM_WM_SCCR;
                `CUPM_OFF_PLL: next_pll = pwdata & `CUPM_WM_PLL; // [R14]
                `CUPM_OFF_CMRR: begin
                    next_mon_on = pwdata[`CUPM_B_MON_ON]; // [R13]
                    next_fail_rst = pwdata[`CUPM_B_FAIL_RST];
                end
                `CUPM_OFF_IMSK: next_imsk = pwdata[3:0];
                default: next_imsk = imsk;
            endcase
        end
        next_fail = fail | fail_evt; // [R10]
        if (wr_ok && paddr == `CUPM_OFF_CMRR && pwdata[`CUPM_B_FAIL])
            next_fail = fail_evt; // [R13]
        next_nmi_st = nmi_st | pin_rise[6:3];
        next_lvi_st = lvi_st | pin_rise[10:7];
        if (wr && paddr == `CUPM_OFF_NMI)
            next_nmi_st = (nmi_st & ~pwdata[3:0]) | pin_rise[6:3]; // [R03]
        if (wr && paddr == `CUPM_OFF_LVI)
            next_lvi_st = (lvi_st & ~pwdata[3:0]) | pin_rise[10:7]; // [R03]
        next_ist = (ist & ~rd_clr) | ev;
        next_irq = |(ist & imsk);
        next_pready = setup;
        next_pslverr = setup && !hit;
        next_prdata = (setup && !pwrite) ? rmux : 32'h0;
        next_fail_reset = fail && fail_rst; // [R10]
        next_fout = fout_of(sccr[`CUPM_B_XSRC] ? XTAL_MHZ : INT_MHZ,
                            pll); // [R16] [R08]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sccr <= `CUPM_RST_REG;
            pll <= `CUPM_RST_REG;
            mon_on <= 1'b0;
            fail_rst <= 1'b0;
            fail <= 1'b0;
            nmi_st <= 4'h0;
            lvi_st <= 4'h0;
            ist <= 4'h0;
            imsk <= 4'h0;
            irq <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            xtal_fail_reset <= 1'b0;
            loop_fout_mhz <= 16'h0;
            lock_q <= 1'b0;
        end else begin
            sccr <= next_sccr;
            pll <= next_pll;
            mon_on <= next_mon_on;
            fail_rst <= next_fail_rst;
            fail <= next_fail;
            nmi_st <= next_nmi_st;
            lvi_st <= next_lvi_st;
            ist <= next_ist;
            imsk <= next_imsk;
            irq <= next_irq;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            xtal_fail_reset <= next_fail_reset;
            loop_fout_mhz <= next_fout;
            lock_q <= lock_st;
        end
    end

    assign main_clock_select = sccr[`CUPM_F_MCS];
    assign loop_source_select = sccr[`CUPM_B_XSRC]; // [R16]
    assign loop_reset_release = pll[`CUPM_B_RSTREL]; // [R14]
    assign loop_power_on = pll[`CUPM_B_PWRON];
    assign loop_bypass_off = pll[`CUPM_B_BYPOFF];
    assign doubler_select = pll[`CUPM_B_DOUBLE];
    assign loop_pre_div = pll[`CUPM_F_PRE];
    assign loop_mult = pll[`CUPM_F_MULT];
    assign loop_post_div = pll[`CUPM_F_POST];
    assign loop_out_div = pll[`CUPM_F_OUT];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_locked_write_ignored: assert property (wr && !unlocked |=>
        $stable(sccr) && $stable(pll) && $stable(imsk))
        else $error("locked write changed a register"); // [R19]
    chk_write_gate_open: assert property (wr && unlocked &&
        paddr == `CUPM_OFF_SCCR |=> sccr == ($past(pwdata) &
        `CUPM_WM_SCCR)) else $error("open write not stored"); // [R17]
    chk_nmi_clear_any: assert property (wr && paddr == `CUPM_OFF_NMI &&
        pwdata[0] && !pin_rise[3] |=> !nmi_st[0])
        else $error("status bit not cleared"); // [R03]
    chk_unlock_readback: assert property (setup && !pwrite &&
        paddr == `CUPM_OFF_KEY |=> pready &&
        prdata[`CUPM_B_UNLOCK] == $past(unlocked))
        else $error("unlock bit read wrong"); // [R04]
    chk_fail_w1c: assert property (wr_ok && paddr == `CUPM_OFF_CMRR &&
        pwdata[`CUPM_B_FAIL] && !fail_evt |=> !fail)
        else $error("fail flag not cleared"); // [R13]
    chk_fail_reset: assert property (fail && fail_rst |=>
        xtal_fail_reset) else $error("fail reset not raised"); // [R10]
    chk_fout_calc: assert property ($stable(pll) && $stable(sccr) ##1
        $stable(pll) && $stable(sccr) |-> loop_fout_mhz == fout_of(
        sccr[`CUPM_B_XSRC] ? XTAL_MHZ : INT_MHZ, pll))
        else $error("output frequency wrong"); // [R08]
    chk_irq_level: assert property ((ist & imsk) != 4'h0 |=> irq)
        else $error("interrupt not raised"); // [R10]
endmodule
`default_nettype wire

// file: bench/clock_unlock_pll_monitor_bench.sv
/*
 Self-checking bench for the clock unlock / loop / monitor block.
 Assumes rtl/ on the include path; the bench drives every pin itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cupm_defs.svh"
module clock_unlock_pll_monitor_bench;
    localparam int MT = 2;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic lsi_clk_in = 1'b0;
    logic xtal_beat_in = 1'b0;
    logic loop_locked_in = 1'b1;
    logic [3:0] nmi_event = 4'h0;
    logic [3:0] lvi_event = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, lss, lrr, lpo, lbo, dbl, xfr;
    logic [2:0] mcs, pre;
    logic [7:0] mult;
    logic [3:0] post, outd;
    logic [15:0] fout;
    int mismatches = 0;
    int tests_run = 0;
    int cyc = 0;
    int bc = 0;
    logic beat_on = 1'b1;

    cupm_top #(.MON_TICKS(MT)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .lsi_clk_in(lsi_clk_in), .xtal_beat_in(xtal_beat_in),
        .loop_locked_in(loop_locked_in), .nmi_event(nmi_event),
        .lvi_event(lvi_event), .main_clock_select(mcs),
        .loop_source_select(lss), .loop_reset_release(lrr),
        .loop_power_on(lpo), .loop_bypass_off(lbo), .doubler_select(dbl),
        .loop_pre_div(pre), .loop_mult(mult), .loop_post_div(post),
        .loop_out_div(outd), .loop_fout_mhz(fout), .xtal_fail_reset(xfr)
    );

    always #12.5 pclk = ~pclk;

    // Slow osc never stops; crystal beat can be halted for the monitor
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        bc <= (bc == 5) ? 0 : bc + 1;
        if (cyc % 8 == 0)
            lsi_clk_in <= ~lsi_clk_in;
        if (beat_on && bc == 5)
            xtal_beat_in <= ~xtal_beat_in;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, g, x);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [31:0] m);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask

    // Integer MHz: bypassed loop passes the reference straight through
    function automatic logic [31:0] fexp(logic x, logic [31:0] p);
        logic [31:0] f;
        f = x ? 32'd8 : 32'd32;
        if (p[21])
            f = f * (p[15:8] + 32'd1) * (p[20] + 32'd1)
                / ((p[18:16] + 32'd1) * (p[7:4] + 32'd1) * (p[3:0] + 32'd1));
        return f;
    endfunction

    initial begin
        logic [31:0] r, s, p;
        logic e;
        r = $urandom(12);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        idle(2);
        chk({16'h0, fout}, 32'h20);
        rd(`CUPM_OFF_KEY, 32'h0, 32'hffff_ffff);
        rd(`CUPM_OFF_PLL, 32'h0, 32'hffff_ffff);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h8000_0000);
        wr(`CUPM_OFF_SCCR, 32'h0000_1007);
        rd(`CUPM_OFF_SCCR, 32'h0, 32'hffff_ffff);
        chk({29'h0, mcs}, 32'h0);
        nmi_event <= 4'h5;
        lvi_event <= 4'ha;
        idle(4);
        nmi_event <= 4'h0;
        lvi_event <= 4'h0;
        idle(4);
        chk({31'h0, irq}, 32'h0);
        rd(`CUPM_OFF_NMI, 32'h5, 32'hffff_ffff);
        wr(`CUPM_OFF_NMI, 32'h1);
        rd(`CUPM_OFF_NMI, 32'h4, 32'hffff_ffff);
        wr(`CUPM_OFF_LVI, 32'ha);
        rd(`CUPM_OFF_LVI, 32'h0, 32'hffff_ffff);
        rd(`CUPM_OFF_IST, 32'hc, 32'hffff_ffff);
        rd(`CUPM_OFF_IST, 32'h0, 32'hffff_ffff);
        wr(`CUPM_OFF_KEY, 32'h57);
        wr(`CUPM_OFF_KEY, 32'h11);
        rd(`CUPM_OFF_KEY, 32'h0, 32'hffff_ffff);
        wr(`CUPM_OFF_KEY, 32'h75);
        rd(`CUPM_OFF_KEY, 32'h0, 32'hffff_ffff);
        wr(`CUPM_OFF_KEY, 32'h57);
        wr(`CUPM_OFF_KEY, 32'h75);
        rd(`CUPM_OFF_KEY, 32'h100, 32'hffff_ffff);
        wr(`CUPM_OFF_IMSK, 32'hf);
        rd(`CUPM_OFF_IMSK, 32'hf, 32'hffff_ffff);
        // Last two passes: 96 MHz from the crystal, then doubled
        for (int i = 0; i < 10; i++) begin
            s = $urandom & `CUPM_WM_SCCR;
            p = $urandom & `CUPM_WM_PLL;
            if (i == 8)
                p = 32'h00e3_2f00;
            if (i == 9)
                p = 32'h00f3_2f00;
            if (i >= 8)
                s = 32'h0000_1007;
            wr(`CUPM_OFF_PLL, p);
            rd(`CUPM_OFF_PLL, {p[23] & p[22], p[30:0]}, 32'hffff_ffff);
            // Loop only becomes the main clock once it reports lock
            if (!(p[23] && p[22]) && s[2:0] == 3'h7)
                s[2:0] = 3'h0;
            wr(`CUPM_OFF_SCCR, s);
            rd(`CUPM_OFF_SCCR, s, 32'hffff_ffff);
            idle(3);
            chk({19'h0, lss, 9'h0, mcs}, s);
            chk({8'h0, lrr, lpo, lbo, dbl, p[19], pre, mult, post, outd}, p);
            chk({16'h0, fout}, fexp(s[12], p));
        end
        chk({31'h0, irq}, 32'h1);
        rd(`CUPM_OFF_IST, 32'h2, 32'h2);
        rd(`CUPM_OFF_IST, 32'h0, 32'hffff_ffff);
        idle(2);
        chk({31'h0, irq}, 32'h0);
        loop_locked_in <= 1'b0;
        idle(4);
        rd(`CUPM_OFF_PLL, 32'h0, 32'h8000_0000);
        loop_locked_in <= 1'b1;
        idle(4);
        rd(`CUPM_OFF_PLL, 32'h8000_0000, 32'h8000_0000);
        rd(`CUPM_OFF_IST, 32'h2, 32'hffff_ffff);
        wr(`CUPM_OFF_KEY, 32'h0);
        rd(`CUPM_OFF_KEY, 32'h0, 32'hffff_ffff);
        wr(`CUPM_OFF_SCCR, 32'h0);
        rd(`CUPM_OFF_SCCR, 32'h1007, 32'hffff_ffff);
        wr(`CUPM_OFF_KEY, 32'h57);
        wr(`CUPM_OFF_KEY, 32'h75);
        wr(`CUPM_OFF_SCCR, 32'h0);
        beat_on <= 1'b0;
        wr(`CUPM_OFF_CMRR, 32'h8);
        idle(80);
        chk({31'h0, irq}, 32'h1);
        rd(`CUPM_OFF_CMRR, 32'ha, 32'hffff_ffff);
        rd(`CUPM_OFF_IST, 32'h1, 32'h1);
        wr(`CUPM_OFF_CMRR, 32'h2);
        rd(`CUPM_OFF_CMRR, 32'h0, 32'hffff_ffff);
        wr(`CUPM_OFF_CMRR, 32'hc);
        idle(80);
        chk({31'h0, xfr}, 32'h1);
        rd(`CUPM_OFF_IST, 32'h0, 32'h1);
        wr(`CUPM_OFF_CMRR, 32'h2);
        idle(2);
        chk({31'h0, xfr}, 32'h0);
        beat_on <= 1'b1;
        wr(`CUPM_OFF_CMRR, 32'h8);
        idle(80);
        rd(`CUPM_OFF_CMRR, 32'h8, 32'hffff_ffff);
        print_verdict();
    end
endmodule
`default_nettype wire
